// ===== pdrc_pkg.sv
// Package with register map, field positions, reset values and timing constants of the piezo drive block
package pdrc_pkg;
   // Register addresses
   localparam logic [7:0] ADDR_CTRL      = 8'h00;
   localparam logic [7:0] ADDR_PER_LOW   = 8'h01;
   localparam logic [7:0] ADDR_PULSE_HI  = 8'h02;
   localparam logic [7:0] ADDR_PULSE_LO  = 8'h03;
   localparam logic [7:0] ADDR_DUTY      = 8'h04;
   localparam logic [7:0] ADDR_PHASE     = 8'h05;
   localparam logic [7:0] ADDR_TRIM      = 8'h06;
   localparam logic [7:0] ADDR_BLEND     = 8'h07;
   localparam logic [7:0] ADDR_TEST      = 8'h10;
   // Reset values
   localparam logic [7:0] RST_CTRL       = 8'h63;
   localparam logic [7:0] RST_ZERO       = 8'h00;
   localparam logic [7:0] RST_BLEND      = 8'h80;
   // Control register fields
   localparam int CTRL_PS_LSB   = 5;
   localparam int CTRL_CN_LSB   = 2;
   localparam int CTRL_PA_BIT   = 1;
   localparam int CTRL_PB_BIT   = 0;
   localparam logic [7:0] CTRL_WR_MASK = 8'h6f;
   // Pulse count high byte fields
   localparam int PHI_PER_MSB   = 7;
   localparam int PHI_DIR_BIT   = 6;
   localparam int PHI_DS_LSB    = 4;
   // Period trim register fields
   localparam int TRIM_IDLE_BIT = 7;
   localparam int TRIM_HB_BIT   = 6;
   localparam int TRIM_HYB_BIT  = 5;
   localparam int TRIM_DT_BIT   = 4;
   // Calibrate-now encodings
   localparam logic [1:0] CAL_NONE  = 2'h0;
   localparam logic [1:0] CAL_INCR  = 2'h1;
   localparam logic [1:0] CAL_SWEEP = 2'h2;
   // Slave address upper six bits
   localparam logic [5:0] SLV_ADDR_HI = 6'h2a;
   // Dead time in oscillator cycles: base and step per selection code
   localparam logic [3:0] DT_BASE_CYC = 4'h2;
   localparam logic [3:0] DT_STEP_CYC = 4'h2;
   // Clock rate of the system clock in hertz
   localparam int CLK_HZ = 25000000;
   typedef enum logic [2:0] {
      ST_IDLE, ST_ADDR, ST_REG, ST_WDATA, ST_ACK, ST_RDATA, ST_RACK
   } pdrc_i2c_state_t;
endpackage

// ===== pdrc_top.sv
// Piezo drive register bank, two-wire slave and drive period generator
//
// Summary of operation
// - Byte registers 00h-07h plus 10h
// - Location 10h unreachable in normal use
// - Control starts calibration, selects and enables phases
// - Bits 6:5 pick sensed phase, reset 11
// - Bits 3:2 calibrate none/incremental/sweep, reset 00
// - Bits 1,0 enable phases, reset set
// - Period is 9 bits, MSB from 02h bit7
// - Switching period divides oscillator by count
// - 02h bit 6 sets motion direction
// - 02h bits 5:4 pick 2/4/6/8 dead cycles
// - Selected dead time only with long-deadtime bit
// - 06h bits: idle, half-bridge, blend, long deadtime
// - Half-bridge only while supply above threshold
// - Period offset only when calibrate field 00
// - Offset ignored while tracking runs
// - Tracking waits for a written pulse count; trigger follows bits 3:2 at once
// - Zero pulse count stops motor, outputs low
// - Seven-bit slave address, LSB from strap
`timescale 1ns/1ps
module pdrc_top (
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe_n,
   input  wire logic       addr_strap,
   input  wire logic       supply_above_threshold,
   output logic            drive_a_hi,
   output logic            drive_a_lo,
   output logic            drive_b_hi,
   output logic            drive_b_lo,
   output logic [1:0]      sense_phase_select,
   output logic [1:0]      calibrate_trigger,
   output logic            tracking_active,
   output logic            motion_direction,
   output logic            idle_select,
   output logic            half_bridge_active,
   output logic            blend_speed_allow,
   output logic [7:0]      blend_level,
   output logic [7:0]      duty_width,
   output logic [7:0]      phase_offset_angle,
   output logic [10:0]     pulses_left
);
   // Input synchronisers
   logic [2:0] scl_sync_ff;
   logic [2:0] sda_sync_ff;
   logic [1:0] strap_sync_ff;
   logic [1:0] supply_sync_ff;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         scl_sync_ff    <= 3'h7;
         sda_sync_ff    <= 3'h7;
         strap_sync_ff  <= 2'h0;
         supply_sync_ff <= 2'h0;
      end else begin
         scl_sync_ff    <= {scl_sync_ff[1:0], scl_in};
         sda_sync_ff    <= {sda_sync_ff[1:0], sda_in};
         strap_sync_ff  <= {strap_sync_ff[0], addr_strap};
         supply_sync_ff <= {supply_sync_ff[0], supply_above_threshold};
      end
   end
   logic scl_rise, scl_fall, bus_start, bus_stop, sda_now;
   assign sda_now   = sda_sync_ff[1];
   assign scl_rise  = scl_sync_ff[1] & ~scl_sync_ff[2];
   assign scl_fall  = ~scl_sync_ff[1] & scl_sync_ff[2];
   assign bus_start = scl_sync_ff[1] & scl_sync_ff[2] & sda_sync_ff[2] & ~sda_now;
   assign bus_stop  = scl_sync_ff[1] & scl_sync_ff[2] & ~sda_sync_ff[2] & sda_now;

   // Register bank
   logic [7:0] ctrl_ff, per_low_ff, pulse_hi_ff, pulse_lo_ff, trim_ff;
   logic [7:0] duty_ff, phase_ff, blend_ff;
   logic       wr_stb_ff;
   logic [7:0] wr_addr_ff, wr_data_ff;

   function automatic logic [7:0] read_mux(input logic [7:0] a);
      case (a)
         pdrc_pkg::ADDR_CTRL:     read_mux = ctrl_ff;
         pdrc_pkg::ADDR_PER_LOW:  read_mux = per_low_ff;
         pdrc_pkg::ADDR_PULSE_HI: read_mux = pulse_hi_ff;
         pdrc_pkg::ADDR_PULSE_LO: read_mux = pulse_lo_ff;
         pdrc_pkg::ADDR_DUTY:     read_mux = duty_ff;
         pdrc_pkg::ADDR_PHASE:    read_mux = phase_ff;
         pdrc_pkg::ADDR_TRIM:     read_mux = trim_ff;
         pdrc_pkg::ADDR_BLEND:    read_mux = blend_ff;
         default:                 read_mux = pdrc_pkg::RST_ZERO;
      endcase
   endfunction

   // Writes outside 00h-07h, the test slot included, fall to the default arm
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_ff     <= pdrc_pkg::RST_CTRL;
         per_low_ff  <= pdrc_pkg::RST_ZERO;
         pulse_hi_ff <= pdrc_pkg::RST_ZERO;
         pulse_lo_ff <= pdrc_pkg::RST_ZERO;
         duty_ff     <= pdrc_pkg::RST_ZERO;
         phase_ff    <= pdrc_pkg::RST_ZERO;
         trim_ff     <= pdrc_pkg::RST_ZERO;
         blend_ff    <= pdrc_pkg::RST_BLEND;
      end else if (wr_stb_ff) begin
         case (wr_addr_ff)
            pdrc_pkg::ADDR_CTRL:     ctrl_ff     <= wr_data_ff & pdrc_pkg::CTRL_WR_MASK;
            pdrc_pkg::ADDR_PER_LOW:  per_low_ff  <= wr_data_ff;
            pdrc_pkg::ADDR_PULSE_HI: pulse_hi_ff <= wr_data_ff;
            pdrc_pkg::ADDR_PULSE_LO: pulse_lo_ff <= wr_data_ff;
            pdrc_pkg::ADDR_DUTY:     duty_ff     <= wr_data_ff;
            pdrc_pkg::ADDR_PHASE:    phase_ff    <= wr_data_ff;
            pdrc_pkg::ADDR_TRIM:     trim_ff     <= wr_data_ff;
            pdrc_pkg::ADDR_BLEND:    blend_ff    <= wr_data_ff;
            default: ;
         endcase
      end
   end

   // Two-wire slave, byte and page write, sequential read
   pdrc_pkg::pdrc_i2c_state_t state_ff, after_ack_ff;
   logic [2:0] bit_cnt_ff;
   logic       got_byte_ff, pull_ff, ack_ok_ff;
   logic [7:0] shift_ff, ptr_ff;
   logic       addr_match;
   assign addr_match = (shift_ff[7:1] == {pdrc_pkg::SLV_ADDR_HI, strap_sync_ff[1]});
   // Read data for the current and the following pointer, ready before the SCL fall that loads it
   logic [7:0] rd_cur, rd_next;
   assign rd_cur  = read_mux(ptr_ff);
   assign rd_next = read_mux(ptr_ff + 8'h01);

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_ff     <= pdrc_pkg::ST_IDLE;
         after_ack_ff <= pdrc_pkg::ST_IDLE;
         bit_cnt_ff   <= 3'h0;
         got_byte_ff  <= 1'b0;
         pull_ff      <= 1'b0;
         ack_ok_ff    <= 1'b0;
         shift_ff     <= 8'h00;
         ptr_ff       <= 8'h00;
         wr_stb_ff    <= 1'b0;
         wr_addr_ff   <= 8'h00;
         wr_data_ff   <= 8'h00;
      end else begin
         wr_stb_ff <= 1'b0;
         if (bus_start) begin
            state_ff    <= pdrc_pkg::ST_ADDR;
            bit_cnt_ff  <= 3'h0;
            got_byte_ff <= 1'b0;
            pull_ff     <= 1'b0;
         end else if (bus_stop) begin
            state_ff <= pdrc_pkg::ST_IDLE;
            pull_ff  <= 1'b0;
         end else if (scl_rise) begin
            case (state_ff)
               pdrc_pkg::ST_ADDR, pdrc_pkg::ST_REG, pdrc_pkg::ST_WDATA: begin
                  shift_ff    <= {shift_ff[6:0], sda_now};
                  bit_cnt_ff  <= bit_cnt_ff + 3'h1;
                  got_byte_ff <= (bit_cnt_ff == 3'h7);
               end
               pdrc_pkg::ST_RDATA: begin
                  bit_cnt_ff  <= bit_cnt_ff + 3'h1;
                  got_byte_ff <= (bit_cnt_ff == 3'h7);
               end
               pdrc_pkg::ST_RACK: ack_ok_ff <= ~sda_now;
               default: ;
            endcase
         end else if (scl_fall) begin
            case (state_ff)
               pdrc_pkg::ST_ADDR: if (got_byte_ff) begin
                  got_byte_ff <= 1'b0;
                  if (addr_match) begin
                     pull_ff      <= 1'b1;
                     state_ff     <= pdrc_pkg::ST_ACK;
                     after_ack_ff <= shift_ff[0] ? pdrc_pkg::ST_RDATA : pdrc_pkg::ST_REG;
                  end else begin
                     state_ff <= pdrc_pkg::ST_IDLE;
                  end
               end
               pdrc_pkg::ST_REG: if (got_byte_ff) begin
                  got_byte_ff  <= 1'b0;
                  ptr_ff       <= shift_ff;
                  pull_ff      <= 1'b1;
                  state_ff     <= pdrc_pkg::ST_ACK;
                  after_ack_ff <= pdrc_pkg::ST_WDATA;
               end
               pdrc_pkg::ST_WDATA: if (got_byte_ff) begin
                  got_byte_ff  <= 1'b0;
                  wr_stb_ff    <= 1'b1;
                  wr_addr_ff   <= ptr_ff;
                  wr_data_ff   <= shift_ff;
                  ptr_ff       <= ptr_ff + 8'h01;
                  pull_ff      <= 1'b1;
                  state_ff     <= pdrc_pkg::ST_ACK;
                  after_ack_ff <= pdrc_pkg::ST_WDATA;
               end
               pdrc_pkg::ST_ACK: begin
                  bit_cnt_ff <= 3'h0;
                  state_ff   <= after_ack_ff;
                  if (after_ack_ff == pdrc_pkg::ST_RDATA) begin
                     shift_ff <= rd_cur;
                     pull_ff  <= ~rd_cur[7];
                  end else begin
                     pull_ff <= 1'b0;
                  end
               end
               pdrc_pkg::ST_RDATA: begin
                  if (got_byte_ff) begin
                     got_byte_ff <= 1'b0;
                     pull_ff     <= 1'b0;
                     state_ff    <= pdrc_pkg::ST_RACK;
                  end else begin
                     shift_ff <= {shift_ff[6:0], 1'b0};
                     pull_ff  <= ~shift_ff[6];
                  end
               end
               pdrc_pkg::ST_RACK: begin
                  if (ack_ok_ff) begin
                     ptr_ff     <= ptr_ff + 8'h01;
                     shift_ff   <= rd_next;
                     pull_ff    <= ~rd_next[7];
                     bit_cnt_ff <= 3'h0;
                     state_ff   <= pdrc_pkg::ST_RDATA;
                  end else begin
                     state_ff <= pdrc_pkg::ST_IDLE;
                  end
               end
               default: ;
            endcase
         end
      end
   end
   assign sda_out  = 1'b0;
   assign sda_oe_n = ~pull_ff;

   // Decoded fields
   logic [1:0] cal_sel;
   logic [8:0] period_count;
   logic [3:0] dead_cycles;
   assign cal_sel      = ctrl_ff[pdrc_pkg::CTRL_CN_LSB +: 2];
   assign period_count = {pulse_hi_ff[pdrc_pkg::PHI_PER_MSB], per_low_ff};
   // Selection code only counts with long dead time enabled
   assign dead_cycles  = trim_ff[pdrc_pkg::TRIM_DT_BIT]
      ? pdrc_pkg::DT_BASE_CYC + pdrc_pkg::DT_STEP_CYC * {2'h0, pulse_hi_ff[pdrc_pkg::PHI_DS_LSB +: 2]}
      : pdrc_pkg::DT_BASE_CYC;

   // Pulse count and calibration gating
   logic        pulse_loaded_ff, pulse_wr;
   logic [10:0] pulses_ff;
   assign pulse_wr = wr_stb_ff & ((wr_addr_ff == pdrc_pkg::ADDR_PULSE_HI) | (wr_addr_ff == pdrc_pkg::ADDR_PULSE_LO));
   logic        period_end, running;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pulse_loaded_ff <= 1'b0;
         pulses_ff       <= 11'h000;
      end else if (pulse_wr) begin
         pulse_loaded_ff <= 1'b1;
         // A zero load stops the motor at once, even mid-count
         pulses_ff <= (wr_addr_ff == pdrc_pkg::ADDR_PULSE_HI) ? {wr_data_ff[2:0], pulse_lo_ff}
                                                                : {pulse_hi_ff[2:0], wr_data_ff};
      end else if (period_end && running) begin
         pulses_ff <= pulses_ff - 11'h001;
      end
   end
   assign running = (pulses_ff != 11'h000) & ~trim_ff[pdrc_pkg::TRIM_IDLE_BIT];

   logic tracking;
   assign tracking = pulse_loaded_ff & ((cal_sel == pdrc_pkg::CAL_INCR) | (cal_sel == pdrc_pkg::CAL_SWEEP));

   // Period generator: offset only when no calibration is requested
   logic [9:0] period_eff;
   logic [9:0] cnt_ff;
   logic [3:0] dead_ff;
   logic       phase_hi_ff;
   assign period_eff = {1'b0, period_count}
      + ((cal_sel == pdrc_pkg::CAL_NONE) ? {7'h00, trim_ff[2:0]} : 10'h000);
   assign period_end = (cnt_ff + 10'h001 >= period_eff);
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff      <= 10'h000;
         phase_hi_ff <= 1'b0;
         dead_ff     <= 4'h0;
      end else begin
         cnt_ff <= (period_end || !running) ? 10'h000 : cnt_ff + 10'h001;
         if (!running) begin
            phase_hi_ff <= 1'b0;
            dead_ff     <= 4'h0;
         end else if (period_end || (cnt_ff + 10'h001 == {1'b0, period_eff[9:1]})) begin
            phase_hi_ff <= period_end;
            dead_ff     <= dead_cycles;
         end else if (dead_ff != 4'h0) begin
            dead_ff <= dead_ff - 4'h1;
         end
      end
   end

   // Registered outputs; both legs low during dead time or when stopped
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         drive_a_hi <= 1'b0;
         drive_a_lo <= 1'b0;
         drive_b_hi <= 1'b0;
         drive_b_lo <= 1'b0;
      end else begin
         drive_a_hi <= running & ctrl_ff[pdrc_pkg::CTRL_PA_BIT] & phase_hi_ff & (dead_ff == 4'h0);
         drive_a_lo <= running & ctrl_ff[pdrc_pkg::CTRL_PA_BIT] & ~phase_hi_ff & (dead_ff == 4'h0);
         drive_b_hi <= running & ctrl_ff[pdrc_pkg::CTRL_PB_BIT] & phase_hi_ff & (dead_ff == 4'h0);
         drive_b_lo <= running & ctrl_ff[pdrc_pkg::CTRL_PB_BIT] & ~phase_hi_ff & (dead_ff == 4'h0);
      end
   end

   assign sense_phase_select = ctrl_ff[pdrc_pkg::CTRL_PS_LSB +: 2];
   assign calibrate_trigger  = cal_sel;
   assign tracking_active    = tracking;
   assign motion_direction   = pulse_hi_ff[pdrc_pkg::PHI_DIR_BIT];
   assign idle_select        = trim_ff[pdrc_pkg::TRIM_IDLE_BIT];
   // Supply monitor level is only trusted after its synchroniser
   assign half_bridge_active = trim_ff[pdrc_pkg::TRIM_HB_BIT] & supply_sync_ff[1];
   assign blend_speed_allow  = trim_ff[pdrc_pkg::TRIM_HYB_BIT];
   assign blend_level        = blend_ff;
   assign duty_width         = duty_ff;
   assign phase_offset_angle = phase_ff;
   assign pulses_left        = pulses_ff;

   a_zero_stops: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (pulses_ff == 11'h000) |=> !(drive_a_hi | drive_a_lo | drive_b_hi | drive_b_lo))
      else $error("Outputs active with zero pulse count");
   a_test_slot_ignored: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (wr_stb_ff && wr_addr_ff > pdrc_pkg::ADDR_BLEND) |=> $stable(ctrl_ff) && $stable(blend_ff) && $stable(trim_ff))
      else $error("Write outside map changed a register");
   a_track_needs_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !pulse_loaded_ff |-> !tracking_active)
      else $error("Tracking without pulse count");
   a_offset_gated: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (cal_sel != pdrc_pkg::CAL_NONE) |-> period_eff == {1'b0, period_count})
      else $error("Offset applied during calibration");
   a_half_bridge_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
      half_bridge_active |-> $past(supply_above_threshold, 2) && trim_ff[pdrc_pkg::TRIM_HB_BIT])
      else $error("Half bridge without supply level");
   a_ctrl_write_lands: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (wr_stb_ff && wr_addr_ff == pdrc_pkg::ADDR_CTRL) |=> ctrl_ff == ($past(wr_data_ff) & pdrc_pkg::CTRL_WR_MASK))
      else $error("Control write lost");
   a_dead_gap: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $rose(phase_hi_ff) && running |=> !drive_a_hi [*2])
      else $error("Dead time shorter than two cycles");
   a_no_overlap: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !(drive_a_hi && drive_a_lo) && !(drive_b_hi && drive_b_lo))
      else $error("Both legs on together");
endmodule // pdrc_top

// ===== pdrc_host_model.sv
// Two-wire bus master model standing in for the host controller
`timescale 1ns/1ps
module pdrc_host_model (
   input  wire logic clk_sys,
   input  wire logic sda_line,
   output logic      scl_line,
   output logic      sda_pull
);
   // Quarter bit in clocks, kept above the slave's synchroniser delay
   localparam int Q = 6;
   initial begin
      scl_line = 1'b1;
      sda_pull = 1'b0;
   end
   task automatic tk();
      repeat (Q) @(posedge clk_sys);
      #1;
   endtask
   task automatic start_c();
      sda_pull = 1'b0;
      tk();
      scl_line = 1'b1;
      tk();
      sda_pull = 1'b1;
      tk();
      scl_line = 1'b0;
      tk();
   endtask
   task automatic stop_c();
      sda_pull = 1'b1;
      tk();
      scl_line = 1'b1;
      tk();
      sda_pull = 1'b0;
      tk();
   endtask
   task automatic bit_x(input logic b, output logic r);
      sda_pull = ~b;
      tk();
      scl_line = 1'b1;
      tk();
      r = sda_line;
      tk();
      scl_line = 1'b0;
      tk();
   endtask
   task automatic send(input logic [7:0] d, inout logic ok);
      logic r;
      for (int i = 7; i >= 0; i--) bit_x(d[i], r);
      bit_x(1'b1, r);
      ok = ok & ~r;
   endtask
   task automatic wr_regs(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d[$], output logic ok);
      ok = 1'b1;
      start_c();
      send({dev, 1'b0}, ok);
      send(ptr, ok);
      foreach (d[i]) send(d[i], ok);
      stop_c();
   endtask
   task automatic rd_regs(input logic [6:0] dev, input logic [7:0] ptr, input int n, output logic [7:0] q[$]);
      logic ok;
      logic r;
      logic [7:0] d;
      q = {};
      ok = 1'b1;
      start_c();
      send({dev, 1'b0}, ok);
      send(ptr, ok);
      start_c();
      send({dev, 1'b1}, ok);
      for (int i = 0; i < n; i++) begin
         for (int j = 7; j >= 0; j--) begin
            bit_x(1'b1, r);
            d[j] = r;
         end
         // Nack on the last byte hands the line back before stop
         bit_x(i == n - 1, r);
         q.push_back(d);
      end
      stop_c();
   endtask
endmodule // pdrc_host_model

// ===== pdrc_top_test.sv
// Self-checking bench for the piezo drive register bank and period generator
`timescale 1ns/1ps
`define CHK(got, exp, what) begin num_checks++; if ((got) !== (exp)) begin n_errors++; \
   $display("wrong value %s expected %0h seen %0h", what, (exp), (got)); end end
module pdrc_top_test;
   logic        clk_sys = 1'b0;
   logic        rst_n = 1'b0;
   logic        addr_strap = 1'b0;
   logic        supply_above_threshold = 1'b0;
   logic        scl_line, sda_pull, sda_out, sda_oe_n, ok;
   logic        drive_a_hi, drive_a_lo, drive_b_hi, drive_b_lo, tracking_active;
   logic        motion_direction, idle_select, half_bridge_active, blend_speed_allow;
   logic [1:0]  sense_phase_select, calibrate_trigger;
   logic [7:0]  blend_level, duty_width, phase_offset_angle;
   logic [10:0] pulses_left;
   logic [7:0]  q[$];
   int          n_errors = 0;
   int          num_checks = 0;
   int          seed = 32'h94ed;
   // Open-drain line with pull-up: low when either party pulls
   wire logic   sda_line = (sda_oe_n | sda_out) & ~sda_pull;
   always #20 clk_sys = ~clk_sys;
   pdrc_top pdrc_top_inst (.clk_sys, .rst_n, .scl_in(scl_line), .sda_in(sda_line), .sda_out, .sda_oe_n,
      .addr_strap, .supply_above_threshold, .drive_a_hi, .drive_a_lo, .drive_b_hi, .drive_b_lo,
      .sense_phase_select, .calibrate_trigger, .tracking_active, .motion_direction, .idle_select,
      .half_bridge_active, .blend_speed_allow, .blend_level, .duty_width, .phase_offset_angle, .pulses_left);
   pdrc_host_model pdrc_host_model_inst (.clk_sys, .sda_line, .scl_line, .sda_pull);
   task automatic summarize();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] ptr, input logic [7:0] d[$]);
      pdrc_host_model_inst.wr_regs({pdrc_pkg::SLV_ADDR_HI, addr_strap}, ptr, d, ok);
      `CHK(ok, 1'b1, "write ack")
   endtask
   task automatic rd(input logic [7:0] ptr, input logic [7:0] e[$]);
      pdrc_host_model_inst.rd_regs({pdrc_pkg::SLV_ADDR_HI, addr_strap}, ptr, e.size(), q);
      foreach (e[i]) `CHK(q[i], e[i], "register")
   endtask
   task automatic wait_lvl(input logic leg, input logic lvl, output int k);
      k = 0;
      while ((leg ? drive_a_lo : drive_a_hi) !== lvl) begin
         @(posedge clk_sys);
         #1;
         k++;
         if (k > 3000) begin
            n_errors++;
            summarize();
         end
      end
   endtask
   function automatic int exp_period(logic [7:0] hi, logic [7:0] lo, logic [7:0] tr, logic [1:0] cal);
      return {hi[7], lo} + ((cal == pdrc_pkg::CAL_NONE) ? tr[2:0] : 3'h0);
   endfunction
   function automatic int exp_dead(logic [1:0] ds, logic dt);
      return dt ? 2 + 2 * ds : 2;
   endfunction
   initial begin
      repeat (100000) @(posedge clk_sys);
      n_errors++;
      summarize();
   end
   initial begin
      int k1;
      int k2;
      logic [7:0] v, hi, lo, tr, c, bl;
      logic [7:0] hi_t[6] = '{8'h01, 8'h01, 8'h01, 8'h81, 8'h01, 8'h01};
      logic [7:0] lo_t[4] = '{8'h14, 8'h14, 8'h14, 8'h05};
      logic [7:0] tr_t[6] = '{8'h00, 8'h03, 8'h03, 8'h00, 8'h05, 8'h07};
      logic [1:0] cal_t[6] = '{2'h0, 2'h0, 2'h1, 2'h0, 2'h2, 2'h0};
      repeat (20) @(posedge clk_sys);
      #1;
      `CHK({sense_phase_select, calibrate_trigger}, 4'hc, "ctrl fields")
      `CHK({drive_a_hi, drive_a_lo, drive_b_hi, drive_b_lo, pulses_left}, 15'h0, "drive idle")
      rst_n = 1'b1;
      repeat (3) @(posedge clk_sys);
      #1;
      rd(pdrc_pkg::ADDR_CTRL, '{8'h63, 0, 0, 0, 0, 0, 0, 8'h80});
      pdrc_host_model_inst.wr_regs({pdrc_pkg::SLV_ADDR_HI, 1'b1}, pdrc_pkg::ADDR_BLEND, '{8'h11}, ok);
      `CHK(ok, 1'b0, "foreign address ack")
      addr_strap = 1'b1;
      wr(pdrc_pkg::ADDR_BLEND, '{8'h40});
      `CHK(blend_level, 8'h40, "blend level")
      addr_strap = 1'b0;
      for (int i = 0; i < 4; i++) begin
         v = 8'($random(seed));
         v[6:5] = i[1:0];
         v[3:2] = ~i[1:0];
         wr(pdrc_pkg::ADDR_CTRL, '{v});
         rd(pdrc_pkg::ADDR_CTRL, '{v & 8'h6f});
         `CHK({sense_phase_select, calibrate_trigger, tracking_active}, {v[6:5], v[3:2], 1'b0}, "ctrl")
      end
      wr(pdrc_pkg::ADDR_TEST, '{8'h5a});
      wr(8'h08, '{8'h3c});
      rd(pdrc_pkg::ADDR_TEST, '{8'h00});
      rd(8'h08, '{8'h00});
      rd(pdrc_pkg::ADDR_BLEND, '{8'h40});
      v = 8'($random(seed));
      hi = {1'b0, v[7], 6'h0};
      c = {v[4:2], 5'h0};
      lo = 8'($random(seed));
      tr = 8'($random(seed));
      bl = 8'($random(seed)) & 8'h7f;
      wr(8'h01, '{8'h7d, hi, 8'h00, lo, tr, c, bl});
      rd(8'h01, '{8'h7d, hi, 8'h00, lo, tr, c, bl});
      `CHK({motion_direction, idle_select, half_bridge_active, blend_speed_allow}, {hi[6], c[7], 1'b0, c[5]}, "mode")
      `CHK({duty_width, phase_offset_angle, blend_level}, {lo, tr, bl}, "values")
      supply_above_threshold = 1'b1;
      repeat (4) @(posedge clk_sys);
      #1;
      `CHK(half_bridge_active, c[6], "half bridge")
      for (int i = 0; i < 6; i++) begin
         lo = (i < 4) ? lo_t[i] : 8'h20 + (8'($random(seed)) & 8'h3f);
         c = {3'h3, 1'b0, cal_t[i], 2'h3};
         wr(pdrc_pkg::ADDR_CTRL, '{c});
         wr(8'h01, '{lo, hi_t[i], 8'h00, 8'h00, 8'h00, tr_t[i]});
         `CHK(tracking_active, c[3:2] != 2'h0, "tracking")
         wait_lvl(1'b0, 1'b0, k1);
         wait_lvl(1'b0, 1'b1, k1);
         wait_lvl(1'b0, 1'b0, k1);
         wait_lvl(1'b0, 1'b1, k2);
         `CHK(k1 + k2, exp_period(hi_t[i], lo, tr_t[i], c[3:2]), "period")
      end
      wr(8'h02, '{8'h85, 8'h50});
      `CHK((11'h550 - pulses_left) <= 11'd2, 1'b1, "pulses loaded")
      wr(8'h02, '{8'h80, 8'h00});
      `CHK({drive_a_hi, drive_a_lo, drive_b_hi, drive_b_lo, pulses_left}, 15'h0, "stopped")
      for (int i = 0; i < 8; i++) begin
         hi = {2'h0, i[1:0], 4'h1};
         wr(8'h01, '{8'h28, hi, 8'h00, 8'h00, 8'h00, {3'h0, i[2], 4'h0}});
         wait_lvl(1'b0, 1'b1, k1);
         wait_lvl(1'b0, 1'b0, k1);
         wait_lvl(1'b1, 1'b1, k2);
         // Dead time may run one clock long
         `CHK(k2 == exp_dead(i[1:0], i[2]) || k2 == exp_dead(i[1:0], i[2]) + 1, 1'b1, "dead time")
         wr(8'h02, '{8'h00, 8'h00});
      end
      wr(pdrc_pkg::ADDR_CTRL, '{8'h61});
      wr(8'h02, '{8'h01, 8'h00});
      k1 = 0;
      k2 = 0;
      repeat (200) begin
         @(posedge clk_sys);
         #1;
         k1 += drive_a_hi | drive_a_lo;
         k2 += drive_b_hi;
      end
      `CHK({k1 == 0, k2 > 0}, 2'b11, "phase enables")
      summarize();
   end
endmodule // pdrc_top_test
